// *** irq_ctrl_map.vh ***
// Register map, field positions and reset values of the core interrupt controller
`ifndef IRQ_CTRL_MAP_VH
`define IRQ_CTRL_MAP_VH

// AXI4-Lite byte offsets
`define ADDR_CONTROL      8'h00
`define ADDR_OPTION       8'h04
`define ADDR_PFLAG_A      8'h08
`define ADDR_PFLAG_B      8'h0C
`define ADDR_PEN_A        8'h10
`define ADDR_PEN_B        8'h14
`define ADDR_CORE         8'h18
`define ADDR_EVT_STATUS   8'h1C
`define ADDR_EVT_CLEAR    8'h20
`define ADDR_EVT_ENABLE   8'h24

// Control register fields
`define BIT_GLOBAL_EN     7
`define BIT_PGROUP_EN     6
`define BIT_TIMER_EN      5
`define BIT_EXT_EN        4
`define BIT_PORT_EN       3
`define BIT_TIMER_FLAG    2
`define BIT_EXT_FLAG      1
`define BIT_PORT_FLAG     0

// Option register field
`define BIT_EDGE_SEL      6

// Core status fields
`define BIT_CORE_SLEEP    0
`define BIT_CORE_INSVC    1

// Event status fields
`define EVT_VECTOR        0
`define EVT_WAKE          1
`define EVT_RETURN        2

// Reset values
`define RST_CONTROL       8'h00
`define RST_OPTION        8'hFF
`define RST_PERIPH        8'h00

// Interrupt vector and latency in instruction cycles
`define IRQ_VECTOR        13'h0004
`define EXT_LATENCY       3

`endif

// *** core_interrupt_controller.v ***
// Core interrupt controller: flags, masking, vectoring, sleep wake-up, AXI4-Lite registers
// How it works
// - Flags set by events regardless of enables
// - Global enable bit 7 gates all vectoring
// - Enabled pending source vectors after the fixed latency of 3 instruction cycles
// - Reset clears the global enable
// - Return instruction sets global enable again
// - Taking interrupt clears enable, pushes, vectors 0004h
// - External event latency fixed, instruction-length independent
// - Peripheral flags/enables in two pairs, group gated
// - Pin edge per select bit sets pin flag
// - Pin enable gates pin interrupt and wake
// - Timer rollover sets timer flag, enable gates
// - Port pins 7:4 change sets port flag
// - Wake sets source flags, vectors if enabled
// - Wake with global clear continues after sleep
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_map.vh"

module core_interrupt_controller #(
	parameter PC_WIDTH = 13,		// Program counter width
	parameter PW       = 8			// Peripheral register width
) (
	input  wire                clk_sys,
	input  wire                reset,
	// AXI4-Lite slave
	input  wire [7:0]          s_axi_awaddr,
	input  wire                s_axi_awvalid,
	output reg                 s_axi_awready,
	input  wire [31:0]         s_axi_wdata,
	input  wire [3:0]          s_axi_wstrb,
	input  wire                s_axi_wvalid,
	output reg                 s_axi_wready,
	output reg  [1:0]          s_axi_bresp,
	output reg                 s_axi_bvalid,
	input  wire                s_axi_bready,
	input  wire [7:0]          s_axi_araddr,
	input  wire                s_axi_arvalid,
	output reg                 s_axi_arready,
	output reg  [31:0]         s_axi_rdata,
	output reg  [1:0]          s_axi_rresp,
	output reg                 s_axi_rvalid,
	input  wire                s_axi_rready,
	// Pins
	input  wire                ext_irq_pin,
	input  wire [7:4]          port_b_pins,
	// Internal sources
	input  wire [7:0]          timer_zero_count,
	input  wire [PW-1:0]       periph_event_a,
	input  wire [PW-1:0]       periph_event_b,
	// Core interface
	input  wire                instr_cycle,		// One pulse per instruction cycle
	input  wire [PC_WIDTH-1:0] core_pc,		// Return address to push
	input  wire                return_from_irq_instr,
	input  wire                sleep_instr,
	output reg                 vector_take,		// Pulse: push and load vector
	output reg  [PC_WIDTH-1:0] vector_pc,
	output reg  [PC_WIDTH-1:0] push_pc,
	output reg                 core_sleeping,
	output reg                 wake_pulse,
	output reg                 irq_request,
	output reg                 irq
);

	////////////////////////////////////////////////////////////////////////////
	// Storage
	reg [7:0]    irq_control_reg_r;		// Control: enables and core flags
	reg [7:0]    option_r;			// Edge select lives at bit 6
	reg [PW-1:0] periph_flag_reg_a_r;
	reg [PW-1:0] periph_flag_reg_b_r;
	reg [PW-1:0] periph_enable_reg_a_r;
	reg [PW-1:0] periph_enable_reg_b_r;
	reg          inService_r;		// Core is inside the service routine
	reg [2:0]    evtStatus_r;		// Sticky block events
	reg [2:0]    evtEnable_r;
	reg [2:0]    extSync_r;			// Three-stage pin synchroniser
	reg [3:0]    portSync0_r;		// Port stage one
	reg [3:0]    portSync1_r;		// Port stage two
	reg [3:0]    portSync2_r;		// Port stage three
	reg [3:0]    portLast_r;		// Last accepted port value
	reg          extLast_r;			// Last accepted pin level
	reg [7:0]    timerLast_r;		// Previous timer count
	reg [1:0]    latCnt_r;			// Instruction cycles since request
	reg          pend_r;			// Request waiting for vector slot

	// Bus holding registers
	reg          awHeld_r;
	reg          wHeld_r;
	reg [7:0]    awAddr_r;
	reg [31:0]   wData_r;
	reg [3:0]    wStrb_r;

	////////////////////////////////////////////////////////////////////////////
	// Synchronisers and event detection
	wire extStable = (extSync_r[1] == extSync_r[2]);	// Second and third agree
	wire portStable = (portSync1_r == portSync2_r);
	wire edgeSel = option_r[`BIT_EDGE_SEL];
	// Rising when select set, falling when clear
	wire extEdge = extStable && (extSync_r[2] != extLast_r) &&
		(extSync_r[2] == edgeSel);
	wire portChange = portStable && (portSync2_r != portLast_r);
	wire timerRoll = (timerLast_r == 8'hFF) && (timer_zero_count == 8'h00);

	// Pin and port pass three flops; only stage two and three are compared
	always @(posedge clk_sys) begin
		if (reset) begin
			extSync_r <= 3'h0;
			portSync0_r <= 4'h0;
			portSync1_r <= 4'h0;
			portSync2_r <= 4'h0;
			portLast_r <= 4'h0;
			extLast_r <= 1'b0;
			timerLast_r <= 8'h00;
		end else begin
			extSync_r <= {extSync_r[1:0], ext_irq_pin};
			portSync0_r <= port_b_pins;
			portSync1_r <= portSync0_r;
			portSync2_r <= portSync1_r;
			if (extStable)
				extLast_r <= extSync_r[2];
			if (portStable)
				portLast_r <= portSync2_r;
			timerLast_r <= timer_zero_count;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Request forming
	wire [7:0] ctl = irq_control_reg_r;
	wire coreAny = (ctl[`BIT_TIMER_FLAG] & ctl[`BIT_TIMER_EN]) |
		(ctl[`BIT_EXT_FLAG] & ctl[`BIT_EXT_EN]) |
		(ctl[`BIT_PORT_FLAG] & ctl[`BIT_PORT_EN]);
	wire periphAny = ctl[`BIT_PGROUP_EN] &
		(|(periph_flag_reg_a_r & periph_enable_reg_a_r) |
		 |(periph_flag_reg_b_r & periph_enable_reg_b_r));
	wire anyEnabled = coreAny | periphAny;
	wire request = ctl[`BIT_GLOBAL_EN] & anyEnabled;
	// Vector on an instruction boundary once the fixed latency has passed.
	// Counting instruction cycles, not clocks, keeps two-cycle
	// instructions from stretching the latency.
	wire takeNow = request & ~core_sleeping & instr_cycle &
		(latCnt_r == 2'd`EXT_LATENCY - 2'd1);

	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire wrFire = awHeld_r & wHeld_r & ~s_axi_bvalid;
	wire rdFire = s_axi_arvalid & s_axi_arready;

	function [7:0] merge8;
		input [7:0] old;
		input [31:0] data;
		input [3:0] strb;
		begin
			merge8 = strb[0] ? data[7:0] : old;
		end
	endfunction

	function hit;
		input [7:0] a;
		input [7:0] b;
		begin
			hit = (a[7:2] == b[7:2]);
		end
	endfunction

	wire wCtl = wrFire & hit(awAddr_r, `ADDR_CONTROL);
	wire [7:0] ctlWr = merge8(ctl, wData_r, wStrb_r);

	////////////////////////////////////////////////////////////////////////////
	// Control register, flags and sequencing
	always @(posedge clk_sys) begin
		if (reset) begin
			irq_control_reg_r <= `RST_CONTROL;
			option_r <= `RST_OPTION;
			periph_flag_reg_a_r <= `RST_PERIPH;
			periph_flag_reg_b_r <= `RST_PERIPH;
			periph_enable_reg_a_r <= `RST_PERIPH;
			periph_enable_reg_b_r <= `RST_PERIPH;
			inService_r <= 1'b0;
			latCnt_r <= 2'd0;
			pend_r <= 1'b0;
			core_sleeping <= 1'b0;
			wake_pulse <= 1'b0;
			vector_take <= 1'b0;
			vector_pc <= {PC_WIDTH{1'b0}};
			push_pc <= {PC_WIDTH{1'b0}};
			irq_request <= 1'b0;
		end else begin
			vector_take <= 1'b0;
			wake_pulse <= 1'b0;
			irq_request <= request;
			// Software write first; hardware sets below override it
			if (wCtl)
				irq_control_reg_r <= ctlWr;
			if (wrFire && hit(awAddr_r, `ADDR_OPTION))
				option_r <= merge8(option_r, wData_r, wStrb_r);
			if (wrFire && hit(awAddr_r, `ADDR_PFLAG_A))
				periph_flag_reg_a_r <= merge8(periph_flag_reg_a_r, wData_r, wStrb_r)
					| periph_event_a;
			else
				periph_flag_reg_a_r <= periph_flag_reg_a_r | periph_event_a;
			if (wrFire && hit(awAddr_r, `ADDR_PFLAG_B))
				periph_flag_reg_b_r <= merge8(periph_flag_reg_b_r, wData_r, wStrb_r)
					| periph_event_b;
			else
				periph_flag_reg_b_r <= periph_flag_reg_b_r | periph_event_b;
			if (wrFire && hit(awAddr_r, `ADDR_PEN_A))
				periph_enable_reg_a_r <= merge8(periph_enable_reg_a_r, wData_r, wStrb_r);
			if (wrFire && hit(awAddr_r, `ADDR_PEN_B))
				periph_enable_reg_b_r <= merge8(periph_enable_reg_b_r, wData_r, wStrb_r);
			// Event flags win over a clearing write in the same cycle
			if (extEdge)
				irq_control_reg_r[`BIT_EXT_FLAG] <= 1'b1;
			if (timerRoll)
				irq_control_reg_r[`BIT_TIMER_FLAG] <= 1'b1;
			if (portChange)
				irq_control_reg_r[`BIT_PORT_FLAG] <= 1'b1;
			// Latency counter runs on instruction cycles while requested
			if (!request || core_sleeping)
				latCnt_r <= 2'd0;
			else if (instr_cycle && !takeNow)
				latCnt_r <= latCnt_r + 2'd1;
			// Sleep entry; a pending enabled source turns sleep into a no-op
			if (sleep_instr && !core_sleeping && !anyEnabled)
				core_sleeping <= 1'b1;
			// Wake on any enabled source regardless of global enable
			if (core_sleeping && anyEnabled) begin
				core_sleeping <= 1'b0;
				wake_pulse <= 1'b1;
				// Global set: vector after the next instruction
				pend_r <= ctl[`BIT_GLOBAL_EN];
			end
			if (takeNow || (pend_r && instr_cycle && request)) begin
				irq_control_reg_r[`BIT_GLOBAL_EN] <= 1'b0;
				push_pc <= core_pc;
				vector_pc <= `IRQ_VECTOR;
				vector_take <= 1'b1;
				inService_r <= 1'b1;
				pend_r <= 1'b0;
				latCnt_r <= 2'd0;
			end else if (pend_r && !request)
				pend_r <= 1'b0;
			if (return_from_irq_instr) begin
				irq_control_reg_r[`BIT_GLOBAL_EN] <= 1'b1;
				inService_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Block event status, clear and enable; interrupt output
	wire [2:0] evtSet = {return_from_irq_instr, core_sleeping & anyEnabled,
		takeNow | (pend_r & instr_cycle & request)};
	wire wClr = wrFire & hit(awAddr_r, `ADDR_EVT_CLEAR);

	// Set wins over a clear in the same cycle
	always @(posedge clk_sys) begin
		if (reset) begin
			evtStatus_r <= 3'h0;
			evtEnable_r <= 3'h0;
			irq <= 1'b0;
		end else begin
			evtStatus_r <= (evtStatus_r & ~(wClr ? wData_r[2:0] : 3'h0)) | evtSet;
			if (wrFire && hit(awAddr_r, `ADDR_EVT_ENABLE))
				evtEnable_r <= wData_r[2:0];
			irq <= |(evtStatus_r & evtEnable_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write channel: address and data taken in either order
	always @(posedge clk_sys) begin
		if (reset) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h0000_0000;
			wStrb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			s_axi_awready <= ~awHeld_r & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~wHeld_r & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (wrFire) begin
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Unmapped offsets answer with a slave error
				s_axi_bresp <= (awAddr_r > `ADDR_EVT_ENABLE + 8'h03) ? 2'b10 : 2'b00;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read channel; status register is read-only, clear reads zero
	reg [31:0] rdMux;
	always @* begin
		rdMux = 32'h0000_0000;
		case (s_axi_araddr[7:2])
			6'h00: rdMux[7:0] = ctl;
			6'h01: rdMux[7:0] = option_r;
			6'h02: rdMux[PW-1:0] = periph_flag_reg_a_r;
			6'h03: rdMux[PW-1:0] = periph_flag_reg_b_r;
			6'h04: rdMux[PW-1:0] = periph_enable_reg_a_r;
			6'h05: rdMux[PW-1:0] = periph_enable_reg_b_r;
			6'h06: rdMux[1:0] = {inService_r, core_sleeping};
			6'h07: rdMux[2:0] = evtStatus_r;
			6'h09: rdMux[2:0] = evtEnable_r;
			default: rdMux = 32'h0000_0000;
		endcase
	end

	always @(posedge clk_sys) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else begin
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (rdFire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdMux;
				s_axi_rresp <= (s_axi_araddr > `ADDR_EVT_ENABLE + 8'h03) ? 2'b10 : 2'b00;
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule // core_interrupt_controller
`default_nettype wire

// *** core_interrupt_controller_chk.sv ***
// Port assertions for the core interrupt controller
`timescale 1ns/1ps
`default_nettype none
module core_interrupt_controller_chk #(
	parameter PC_WIDTH = 13	// Program counter width
) (
	input wire logic                clk_sys,
	input wire logic                reset,
	input wire logic                instr_cycle,
	input wire logic                return_from_irq_instr,
	input wire logic                sleep_instr,
	input wire logic                vector_take,
	input wire logic [PC_WIDTH-1:0] vector_pc,
	input wire logic                core_sleeping,
	input wire logic                wake_pulse,
	input wire logic                irq_request,
	input wire logic                irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////////////////////
	// A take that no return pulse just before it can undo
	sequence s_fresh_take;
		!return_from_irq_instr ##1 vector_take;
	endsequence
	// Entry into sleep is one clock behind the sleep instruction
	sequence s_sleep_entry;
		sleep_instr ##1 $rose(core_sleeping);
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	// Reset must leave the core undisturbed, so it is not masked here
	a_reset_quiet: assert property (@(posedge clk_sys) disable iff (1'b0)
		reset |=> !vector_take && !irq_request && !irq && !wake_pulse)
		else $error("outputs active after reset");
	a_take_needs_request: assert property (vector_take |-> $past(irq_request))
		else $error("vector taken without request");
	a_take_on_instr: assert property (vector_take |-> $past(instr_cycle))
		else $error("vector taken off an instruction boundary");
	a_vector_address: assert property (vector_take |=> vector_pc == 13'h0004)
		else $error("vector address wrong");
	a_take_clears_global: assert property (s_fresh_take |=> !irq_request)
		else $error("request stays after vector");
	a_wake_from_sleep: assert property (wake_pulse |-> $past(core_sleeping))
		else $error("wake without sleep");
	a_sleep_entry_cause: assert property ($rose(core_sleeping) |-> $past(sleep_instr))
		else $error("sleep without instruction");
	a_no_take_asleep: assert property (core_sleeping |-> !vector_take)
		else $error("vector taken while asleep");
	c_sleep_entry: cover property (s_sleep_entry);
endmodule // core_interrupt_controller_chk

bind core_interrupt_controller core_interrupt_controller_chk #(
	.PC_WIDTH(PC_WIDTH)
) i_core_interrupt_controller_chk (
	.clk_sys(clk_sys), .reset(reset), .instr_cycle(instr_cycle),
	.return_from_irq_instr(return_from_irq_instr), .sleep_instr(sleep_instr),
	.vector_take(vector_take), .vector_pc(vector_pc), .core_sleeping(core_sleeping),
	.wake_pulse(wake_pulse), .irq_request(irq_request), .irq(irq)
);
`default_nettype wire

// *** core_model.sv ***
// Behavioural model of the processor core facing the controller
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        vector_take,
	input  wire logic        core_sleeping,
	input  wire logic        retReq,	// Bench asks for a return instruction
	input  wire logic        sleepReq,	// Bench asks for a sleep instruction
	output var  logic        instr_cycle,
	output var  logic [12:0] core_pc,
	output var  logic        return_from_irq_instr,
	output var  logic        sleep_instr
);
	logic [1:0] phase_r;	// Clock within one instruction cycle
	////////////////////////////////////////////////////////////////////////////////
	// Four clocks per instruction; the instruction clock stands still in sleep
	always @(posedge clk_sys) begin
		instr_cycle           <= 1'b0;
		return_from_irq_instr <= 1'b0;
		sleep_instr           <= 1'b0;
		if (reset) begin
			phase_r <= 2'h0;
			core_pc <= 13'h0000;
		end else if (vector_take) begin
			core_pc <= 13'h0004;	// Branch to the fixed vector
		end else if (!core_sleeping) begin
			phase_r <= phase_r + 2'h1;
			if (phase_r == 2'h3) begin
				instr_cycle           <= 1'b1;
				core_pc               <= core_pc + 13'h0001;
				return_from_irq_instr <= retReq;
				sleep_instr           <= sleepReq;
			end
		end
	end
endmodule // core_model
`default_nettype wire

// *** tb_core_interrupt_controller.sv ***
// Self-checking testbench of the core interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_map.vh"
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin errors++; \
$display("CHECK FAILED %0t got %0h expected %0h", $time, (a), (b)); end end
module tb_core_interrupt_controller;
	logic        clk_sys = 1'b0, reset = 1'b1;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0]  s_axi_wstrb = 4'h1;	// Only the low byte is mapped
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0, ext_irq_pin = 1'b0;
	logic [7:4]  port_b_pins = 4'h0;
	logic [7:0]  timer_zero_count = 8'h00, periph_event_a = 8'h00, periph_event_b = 8'h00;
	logic        retReq = 1'b0, sleepReq = 1'b0;	// Requests to the core model
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	wire         instr_cycle, return_from_irq_instr, sleep_instr, vector_take;
	wire  [12:0] core_pc, vector_pc, push_pc;
	wire         core_sleeping, wake_pulse, irq_request, irq;
	int          errors = 0, checksDone = 0, cycles = 0, takes = 0, n;
	logic [31:0] d;	// Last read word
	core_interrupt_controller i_core_interrupt_controller (.clk_sys, .reset, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .ext_irq_pin, .port_b_pins, .timer_zero_count, .periph_event_a,
		.periph_event_b, .instr_cycle, .core_pc, .return_from_irq_instr, .sleep_instr,
		.vector_take, .vector_pc, .push_pc, .core_sleeping, .wake_pulse, .irq_request, .irq);
	core_model i_core_model (.clk_sys, .reset, .vector_take, .core_sleeping, .retReq,
		.sleepReq, .instr_cycle, .core_pc, .return_from_irq_instr, .sleep_instr);
	always #20 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////////////
	// Count vectors and cut a hang short
	always @(posedge clk_sys) begin
		cycles++;
		if (vector_take)
			takes++;
		if (cycles == 20000) begin
			errors++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Register write; bready is raised with the request, so no extra wait
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		@(posedge clk_sys);
	endtask
	// Register read compared with an expected word and response
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		`CHK(s_axi_rdata, e)
		`CHK(s_axi_rresp, r)
		s_axi_rready <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checksDone, errors);
		if (errors == 0 && checksDone > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		rdChk(`ADDR_CONTROL, 32'h0000_0000, 2'h0);
		rdChk(`ADDR_OPTION, 32'h0000_00FF, 2'h0);
		rdChk(8'h28, 32'h0000_0000, 2'h2);
		$display("test reset done");
		// Every source fires with all enables clear
		timer_zero_count <= 8'hFF;
		@(posedge clk_sys);
		timer_zero_count <= 8'h00;
		ext_irq_pin <= 1'b1;
		port_b_pins <= 4'h5;
		periph_event_a <= 8'h08;
		periph_event_b <= 8'h01;
		@(posedge clk_sys);
		periph_event_a <= 8'h00;
		periph_event_b <= 8'h00;
		repeat (8) @(posedge clk_sys);
		rdChk(`ADDR_CONTROL, 32'h0000_0007, 2'h0);
		rdChk(`ADDR_PFLAG_A, 32'h0000_0008, 2'h0);
		rdChk(`ADDR_PFLAG_B, 32'h0000_0001, 2'h0);
		`CHK(takes, 0)
		$display("test flags done");
		// Falling edge select: only the falling edge counts
		wr(`ADDR_CONTROL, 32'h0000_0000);
		wr(`ADDR_OPTION, 32'h0000_0000);
		ext_irq_pin <= 1'b0;
		repeat (8) @(posedge clk_sys);
		rdChk(`ADDR_CONTROL, 32'h0000_0002, 2'h0);
		wr(`ADDR_CONTROL, 32'h0000_0090);
		rdChk(`ADDR_CONTROL, 32'h0000_0090, 2'h0);
		$display("test edge done");
		// Pin edge to vector, then service and return
		ext_irq_pin <= 1'b1;
		repeat (8) @(posedge clk_sys);
		ext_irq_pin <= 1'b0;
		for (n = 0; n < 12 && !vector_take; ) begin
			@(posedge clk_sys);
			if (instr_cycle)
				n++;
		end
		`CHK(n == 3 || n == 4, 1'b1)
		`CHK(push_pc, core_pc)
		@(posedge clk_sys);
		`CHK(vector_pc, 13'h0004)
		rdChk(`ADDR_CONTROL, 32'h0000_0012, 2'h0);
		rdChk(`ADDR_CORE, 32'h0000_0002, 2'h0);
		wr(`ADDR_CONTROL, 32'h0000_0010);
		retReq <= 1'b1;
		for (n = 0; n < 40 && !return_from_irq_instr; n++) @(posedge clk_sys);
		retReq <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rdChk(`ADDR_CONTROL, 32'h0000_0090, 2'h0);
		rdChk(`ADDR_CORE, 32'h0000_0000, 2'h0);
		`CHK(takes, 1)
		$display("test vector done");
		// Peripheral source is held back by the group enable
		wr(`ADDR_PEN_A, 32'h0000_0008);
		wr(`ADDR_CONTROL, 32'h0000_0080);
		repeat (40) @(posedge clk_sys);
		`CHK(takes, 1)
		wr(`ADDR_CONTROL, 32'h0000_00C0);
		for (n = 0; n < 100 && takes < 2; n++) @(posedge clk_sys);
		`CHK(takes, 2)
		wr(`ADDR_PFLAG_A, 32'h0000_0000);
		wr(`ADDR_CONTROL, 32'h0000_0010);
		$display("test group done");
		// Sleep and wake, first with global enable clear, then set
		for (int g = 0; g < 2; g++) begin
			sleepReq <= 1'b1;
			for (n = 0; n < 40 && !core_sleeping; n++) @(posedge clk_sys);
			sleepReq <= 1'b0;
			ext_irq_pin <= 1'b1;
			repeat (8) @(posedge clk_sys);
			ext_irq_pin <= 1'b0;
			for (n = 0; n < 40 && !wake_pulse; n++) @(posedge clk_sys);
			`CHK(wake_pulse, 1'b1)
			repeat (40) @(posedge clk_sys);
			`CHK(core_sleeping, 1'b0)
			`CHK(takes, 2 + g)
			if (g == 0)
				rdChk(`ADDR_CONTROL, 32'h0000_0012, 2'h0);
			wr(`ADDR_CONTROL, 32'h0000_0090);
		end
		$display("test sleep done");
		// Timer rollover vectors through its own enable
		wr(`ADDR_CONTROL, 32'h0000_00A0);
		timer_zero_count <= 8'hFF;
		@(posedge clk_sys);
		timer_zero_count <= 8'h00;
		for (n = 0; n < 100 && takes < 4; n++) @(posedge clk_sys);
		`CHK(takes, 4)
		rdChk(`ADDR_CONTROL, 32'h0000_0024, 2'h0);
		wr(`ADDR_CONTROL, 32'h0000_0090);
		$display("test timer done");
		// Event status, its enable, the interrupt line and clearing
		rdChk(`ADDR_EVT_STATUS, 32'h0000_0007, 2'h0);
		wr(`ADDR_EVT_ENABLE, 32'h0000_0004);
		`CHK(irq, 1'b1)
		wr(`ADDR_EVT_ENABLE, 32'h0000_0000);
		`CHK(irq, 1'b0)
		wr(`ADDR_EVT_STATUS, 32'h0000_0000);
		rdChk(`ADDR_EVT_STATUS, 32'h0000_0007, 2'h0);
		wr(`ADDR_EVT_CLEAR, 32'h0000_0007);
		rdChk(`ADDR_EVT_STATUS, 32'h0000_0000, 2'h0);
		$display("test events done");
		// Low byte not strobed: the write must not land
		s_axi_wstrb <= 4'h0;
		wr(`ADDR_OPTION, 32'h0000_00FF);
		s_axi_wstrb <= 4'h1;
		rdChk(`ADDR_OPTION, 32'h0000_0000, 2'h0);
		// Mid-run reset with global enable set; pins parked so no change follows
		port_b_pins <= 4'h0;
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		@(posedge clk_sys);
		rdChk(`ADDR_CONTROL, 32'h0000_0000, 2'h0);
		rdChk(`ADDR_OPTION, 32'h0000_00FF, 2'h0);
		$display("test second reset done");
		report_and_stop();
	end
endmodule // tb_core_interrupt_controller
`default_nettype wire
